// ==== core/deser_params.svh ====
// constants for the deserializer status and control register bank
`ifndef DESER_PARAMS_SVH
`define DESER_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_DEVICE_STATUS    8'h04
`define OFS_PARITY_LIMIT_HI  8'h05
`define OFS_PARITY_LIMIT_LO  8'h06
`define OFS_TIMEOUT_CFG      8'h07
`define OFS_LOCAL_PORT_CFG   8'h08
`define OFS_IRQ_STATUS       8'h10
`define OFS_IRQ_MASK         8'h11

// ****************************************
// reset values
// ****************************************
`define RST_DEVICE_STATUS    8'hc0
`define RST_PARITY_LIMIT_HI  8'h01
`define RST_PARITY_LIMIT_LO  8'h00
`define RST_TIMEOUT_CFG      8'hfe
`define RST_LOCAL_PORT_CFG   8'h1c
`define RST_IRQ_MASK         4'h0

// ****************************************
// field positions
// ****************************************
`define BIT_CKSUM_OK         7
`define BIT_INIT_DONE        6
`define BIT_REF_OK           4
`define BIT_TIMEOUT_OFF      0
`define BIT_REMOTE_BLOCK     7
`define IRQ_TIMEOUT          0
`define IRQ_REMOTE_REJECT    1
`define IRQ_PARITY           2
`define IRQ_INIT_DONE        3

// ****************************************
// timing
// ****************************************
`define CLK_HZ               10000000
`define CLK_PERIOD_NS        100
`define TIMEOUT_UNIT_MS      2
`define TIMEOUT_TICK_CYCLES  (`TIMEOUT_UNIT_MS * (`CLK_HZ / 1000))
`define SDA_HOLD_UNIT_NS     50
`define GLITCH_UNIT_NS       5
`define REF_WINDOW_NS        16000
`define REF_WINDOW_CYCLES    (`REF_WINDOW_NS / `CLK_PERIOD_NS)
`define REF_PRESCALE         16
`define REF_MIN_MHZ          12
`define REF_MAX_MHZ          64
`define RX_PORTS             4

`endif

// ==== core/deser_pkg.sv ====
// types shared by the register bank and its helpers
package deser_pkg;

	// ****************************************
	// request carriers
	// ****************************************
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} host_req_t;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} remote_req_t;

	typedef enum logic [1:0] {INIT_READY, INIT_LOAD, INIT_WAIT} init_state_t;

	// ****************************************
	// module state
	// ****************************************
	typedef struct packed {
		logic [7:0]  limit_hi;
		logic [7:0]  limit_lo;
		logic [6:0]  wd_time;
		logic        wd_off;
		logic        remote_block;
		logic [2:0]  sda_hold;
		logic [3:0]  glitch_depth;
		logic        cksum_ok;
		logic        init_done;
		init_state_t init_state;
		logic        fuse_start;
		logic [7:0]  rdata;
		logic [3:0]  irq_sts;
		logic [3:0]  irq_mask;
		logic        irq;
		logic        wd_run;
		logic [6:0]  wd_cnt;
		logic [31:0] tick_cnt;
		logic        timeout;
		logic        reject;
		logic        target_go;
		logic [3:0]  flag_prev;
	} regs_state_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic        flag;
	} parity_lane_t;

	typedef struct packed {
		logic       prev;
		logic [7:0] win;
		logic [7:0] edges;
		logic       ok;
	} ref_state_t;

endpackage

// ==== core/ref_clock_checker.sv ====
// reference clock frequency window check
`timescale 1ns/1ps
`default_nettype none
`include "deser_params.svh"

module ref_clock_checker (
	input  wire logic clk_in,
	input  wire logic srst_in,
	input  wire logic ref_div_in,
	output logic      ref_ok_out
);
	import deser_pkg::*;

	localparam logic [7:0] WIN_LAST = 8'(`REF_WINDOW_CYCLES - 1);
	localparam logic [7:0] MIN_EDGES = 8'(`REF_MIN_MHZ);
	localparam logic [7:0] MAX_EDGES = 8'(`REF_MAX_MHZ);

	ref_state_t s_q;
	ref_state_t s_d;

	// ****************************************
	// edge count per window
	// ****************************************
	// the pin is prescaled so the window edge count equals the rate in MHz
	always_comb begin
		s_d = s_q;
		s_d.prev = ref_div_in;
		if (ref_div_in && !s_q.prev && s_q.edges != 8'hff) begin
			s_d.edges = s_q.edges + 8'h01;
		end
		if (s_q.win == WIN_LAST) begin
			s_d.win = 8'h00;
			s_d.edges = 8'h00;
			s_d.ok = (s_q.edges >= MIN_EDGES) && (s_q.edges <= MAX_EDGES);
		end else begin
			s_d.win = s_q.win + 8'h01;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ref_ok_out = s_q.ok;
endmodule
`default_nettype wire

// ==== core/parity_limit_counter.sv ====
// per-port parity error counters against a shared limit
`timescale 1ns/1ps
`default_nettype none
`include "deser_params.svh"

module parity_limit_counter (
	input  wire logic                   clk_in,
	input  wire logic                   srst_in,
	input  wire logic                   check_en_in,
	input  wire logic [15:0]            limit_in,
	input  wire logic [`RX_PORTS-1:0]   error_in,
	input  wire logic [`RX_PORTS-1:0]   clear_in,
	output logic      [`RX_PORTS-1:0]   flag_out
);
	import deser_pkg::*;

	parity_lane_t [`RX_PORTS-1:0] s_q;
	parity_lane_t [`RX_PORTS-1:0] s_d;

	// ****************************************
	// one saturating counter per port
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < `RX_PORTS; g++) begin : lane
			// clear first so a same-cycle error still counts
			always_comb begin
				s_d[g] = s_q[g];
				if (clear_in[g]) begin
					s_d[g] = '0;
				end
				if (check_en_in && error_in[g] && s_d[g].cnt != 16'hffff) begin
					s_d[g].cnt = s_d[g].cnt + 16'h0001;
				end
				if (s_d[g].cnt >= limit_in) begin
					s_d[g].flag = 1'b1;
				end
			end
			assign flag_out[g] = s_q[g].flag;
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// ==== core/deser_status_ctrl_regs.sv ====
// status and control register bank of the deserializer hub
//
// How it works
// - checksum bit set after valid fuse load
// - init-done bit set when fuse load finishes
// - ref clock ok only within 12-64 MHz
// - per-port flag when errors reach limit
// - limit is high byte then low byte
// - watchdog ends stalled control channel transactions
// - timeout is field times 2 ms, reset 0x7F
// - disable bit stops the watchdog, resets enabled
// - remote accesses to attached targets unaffected
// - sda hold is field times 50 ns
// - glitch filter depth is field times 5 ns
// - parity counting only while checker enabled
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "deser_params.svh"

module deser_status_ctrl_regs #(
	parameter int TICK_CYCLES = `TIMEOUT_TICK_CYCLES
) (
	input  wire logic                 clk_in,
	input  wire logic                 srst_in,
	input  wire deser_pkg::host_req_t host_req_in,
	output logic [7:0]                rdata_out,
	input  wire deser_pkg::remote_req_t remote_req_in,
	output logic                      remote_reject_out,
	input  wire logic                 remote_target_req_in,
	output logic                      remote_target_go_out,
	input  wire logic                 rom_reload_in,
	output logic                      fuse_load_start_out,
	input  wire logic                 fuse_load_done_in,
	input  wire logic                 fuse_cksum_valid_in,
	input  wire logic                 ref_clock_div_in,
	input  wire logic                 parity_check_en_in,
	input  wire logic [`RX_PORTS-1:0] parity_error_in,
	input  wire logic [`RX_PORTS-1:0] parity_flag_clear_in,
	output logic [`RX_PORTS-1:0]      parity_flag_out,
	input  wire logic                 txn_start_in,
	input  wire logic                 txn_done_in,
	output logic                      txn_timeout_out,
	output logic [2:0]                sda_hold_out,
	output logic [3:0]                glitch_depth_out,
	output logic                      irq_out
);
	import deser_pkg::*;

	// ****************************************
	// register map
	// ****************************************
	// 0x04 device status, read only:
	//   bit 7 fuse checksum good after last load
	//   bit 6 initialisation finished
	//   bit 4 reference clock within range
	//   other bits read zero
	// 0x05 parity limit, upper byte
	// 0x06 parity limit, lower byte
	// 0x07 control channel timeout:
	//   bits 7..1 timeout in 2 ms steps
	//   bit 0 watchdog off when set
	// 0x08 local serial port:
	//   bit 7 refuse remote local writes
	//   bits 6..4 sda hold code
	//   bits 3..0 glitch filter code
	// 0x10 event status, cleared by read
	// 0x11 event mask, same layout
	// unmapped reads return zero
	// writes to read-only offsets are dropped

	// ****************************************
	// event bits
	// ****************************************
	// bit 0 watchdog expired
	// bit 1 remote write refused
	// bit 2 a parity flag rose
	// bit 3 fuse reload finished
	// a read clears the word, but an event in
	// the same cycle stays set so none is lost
	// irq follows status and mask

	// ****************************************
	// watchdog timing
	// ****************************************
	// a start loads the field and clears the tick
	// counter; each full tick takes one step off
	// the count, and the last step raises the
	// timeout pulse, so expiry lands field ticks
	// after the start is taken
	// done, the off bit or a new start end a run;
	// a new start always reloads from the field
	// the tick counter is wide so a much faster
	// clock still fits without a prescaler

	// ****************************************
	// reset and reload
	// ****************************************
	// reset leaves the status bits set, as if the
	// power-up load had already passed; only a
	// reload request drops them until the loader
	// reports done, so software can poll bit 6
	// the loader's checksum line is read only
	// beside its done strobe, never on its own

	// ****************************************
	// remote path
	// ****************************************
	// control channel writes use the same decode
	// as the host port; the block bit and a host
	// write in the same cycle both refuse them
	// refusals pulse for one cycle and set bit 1
	// accesses to attached targets never see it

	// ****************************************
	// limitations
	// ****************************************
	// the hold and filter codes are only exported;
	// at a 100 ns clock no such delay can be made
	// here, so the pad logic applies them
	// the reference pin arrives divided by 16,
	// which keeps a 64 MHz input countable
	// a zero timeout field is unsupported and
	// simply expires on the first tick

	// hold and filter units, for whoever turns the codes into delays
	localparam int SDA_HOLD_NS_PER_STEP = `SDA_HOLD_UNIT_NS;
	localparam int GLITCH_NS_PER_STEP   = `GLITCH_UNIT_NS;

	regs_state_t s_q;
	regs_state_t s_d;
	logic        ref_ok;
	logic [15:0] parity_limit;

	// ****************************************
	// helpers
	// ****************************************
	// the limit spans two byte registers
	assign parity_limit = {s_q.limit_hi, s_q.limit_lo};

	ref_clock_checker u_ref (
		.clk_in     (clk_in),
		.srst_in    (srst_in),
		.ref_div_in (ref_clock_div_in),
		.ref_ok_out (ref_ok)
	);

	parity_limit_counter u_par (
		.clk_in      (clk_in),
		.srst_in     (srst_in),
		.check_en_in (parity_check_en_in),
		.limit_in    (parity_limit),
		.error_in    (parity_error_in),
		.clear_in    (parity_flag_clear_in),
		.flag_out    (parity_flag_out)
	);

	// ****************************************
	// register write decode
	// ****************************************
	// shared by the local port and the control channel path
	function automatic regs_state_t apply_write(input regs_state_t s, input logic [7:0] a, input logic [7:0] d);
		regs_state_t r;
		r = s;
		case (a)
			`OFS_PARITY_LIMIT_HI: begin
				r.limit_hi = d;
			end
			`OFS_PARITY_LIMIT_LO: begin
				r.limit_lo = d;
			end
			`OFS_TIMEOUT_CFG: begin
				r.wd_time = d[7:1];
				r.wd_off  = d[`BIT_TIMEOUT_OFF];
			end
			`OFS_LOCAL_PORT_CFG: begin
				r.remote_block = d[`BIT_REMOTE_BLOCK];
				r.sda_hold     = d[6:4];
				r.glitch_depth = d[3:0];
			end
			`OFS_IRQ_MASK: begin
				r.irq_mask = d[3:0];
			end
			default: begin
			end
		endcase
		return r;
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.fuse_start = 1'b0;
		s_d.timeout    = 1'b0;
		s_d.reject     = 1'b0;
		s_d.rdata      = 8'h00;
		s_d.flag_prev  = parity_flag_out;

		// remote target traffic passes whatever the block bit says
		s_d.target_go = remote_target_req_in;

		// register writes; a local write wins a same-cycle remote one
		if (host_req_in.wr) begin
			s_d = apply_write(s_d, host_req_in.addr, host_req_in.wdata);
		end
		if (remote_req_in.wr) begin
			if (s_q.remote_block || host_req_in.wr) begin
				s_d.reject = 1'b1;
			end else begin
				s_d = apply_write(s_d, remote_req_in.addr, remote_req_in.wdata);
			end
		end

		// read data, valid in the cycle after the strobe
		if (host_req_in.rd) begin
			case (host_req_in.addr)
				`OFS_DEVICE_STATUS: begin
					s_d.rdata = {s_q.cksum_ok, s_q.init_done, 1'b0, ref_ok, 4'h0};
				end
				`OFS_PARITY_LIMIT_HI: begin
					s_d.rdata = s_q.limit_hi;
				end
				`OFS_PARITY_LIMIT_LO: begin
					s_d.rdata = s_q.limit_lo;
				end
				`OFS_TIMEOUT_CFG: begin
					s_d.rdata = {s_q.wd_time, s_q.wd_off};
				end
				`OFS_LOCAL_PORT_CFG: begin
					s_d.rdata = {s_q.remote_block, s_q.sda_hold, s_q.glitch_depth};
				end
				`OFS_IRQ_STATUS: begin
					s_d.rdata = {4'h0, s_q.irq_sts};
					s_d.irq_sts = 4'h0;
				end
				`OFS_IRQ_MASK: begin
					s_d.rdata = {4'h0, s_q.irq_mask};
				end
				default: begin
					s_d.rdata = 8'h00;
				end
			endcase
		end

		// fuse reload sequence; status bits drop until the load ends
		case (s_q.init_state)
			INIT_READY: begin
				if (rom_reload_in) begin
					s_d.init_done  = 1'b0;
					s_d.cksum_ok   = 1'b0;
					s_d.fuse_start = 1'b1;
					s_d.init_state = INIT_LOAD;
				end
			end
			INIT_LOAD: begin
				s_d.init_state = INIT_WAIT;
			end
			INIT_WAIT: begin
				if (fuse_load_done_in) begin
					s_d.init_done  = 1'b1;
					s_d.cksum_ok   = fuse_cksum_valid_in;
					s_d.init_state = INIT_READY;
					s_d.irq_sts[`IRQ_INIT_DONE] = 1'b1;
				end
			end
			default: begin
				s_d.init_state = INIT_READY;
			end
		endcase

		// control channel watchdog, one 2 ms tick per unit of the field
		if (txn_start_in) begin
			s_d.wd_run   = !s_q.wd_off;
			s_d.wd_cnt   = s_q.wd_time;
			s_d.tick_cnt = 32'h0000_0000;
		end else if (s_q.wd_run) begin
			if (txn_done_in || s_q.wd_off) begin
				s_d.wd_run = 1'b0;
			end else if (s_q.tick_cnt == 32'(TICK_CYCLES - 1)) begin
				s_d.tick_cnt = 32'h0000_0000;
				// a zero field is unsupported; it expires on the first tick
				if (s_q.wd_cnt <= 7'h01) begin
					s_d.wd_run  = 1'b0;
					s_d.timeout = 1'b1;
					s_d.irq_sts[`IRQ_TIMEOUT] = 1'b1;
				end else begin
					s_d.wd_cnt = s_q.wd_cnt - 7'h01;
				end
			end else begin
				s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
			end
		end

		// sticky events; placed after the read clear so a set wins
		if (s_d.reject) begin
			s_d.irq_sts[`IRQ_REMOTE_REJECT] = 1'b1;
		end
		if (|(parity_flag_out & ~s_q.flag_prev)) begin
			s_d.irq_sts[`IRQ_PARITY] = 1'b1;
		end
		s_d.irq = |(s_d.irq_sts & s_d.irq_mask);
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s_q              <= '0;
			s_q.limit_hi     <= `RST_PARITY_LIMIT_HI;
			s_q.limit_lo     <= `RST_PARITY_LIMIT_LO;
			s_q.wd_time      <= 7'(`RST_TIMEOUT_CFG >> 1);
			s_q.wd_off       <= 1'(`RST_TIMEOUT_CFG);
			s_q.remote_block <= 1'(`RST_LOCAL_PORT_CFG >> 7);
			s_q.sda_hold     <= 3'(`RST_LOCAL_PORT_CFG >> 4);
			s_q.glitch_depth <= 4'(`RST_LOCAL_PORT_CFG);
			s_q.cksum_ok     <= 1'(`RST_DEVICE_STATUS >> 7);
			s_q.init_done    <= 1'(`RST_DEVICE_STATUS >> 6);
			s_q.irq_mask     <= `RST_IRQ_MASK;
			s_q.init_state   <= INIT_READY;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// outputs, all straight from flops
	// ****************************************
	// host bus side
	assign rdata_out            = s_q.rdata;

	// control channel side
	assign remote_reject_out    = s_q.reject;
	assign remote_target_go_out = s_q.target_go;

	// fuse loader side
	assign fuse_load_start_out  = s_q.fuse_start;

	// watchdog expiry pulse
	assign txn_timeout_out      = s_q.timeout;

	// pad settings, codes only
	assign sda_hold_out         = s_q.sda_hold;
	assign glitch_depth_out     = s_q.glitch_depth;

	// level interrupt
	assign irq_out              = s_q.irq;
endmodule
`default_nettype wire

// ==== tb/deser_status_ctrl_regs_chk.sv ====
// port assertions for the status and control register bank
`timescale 1ns/1ps
`default_nettype none
`include "deser_params.svh"

module deser_status_ctrl_regs_chk #(
	parameter int TICK_CYCLES = 5
) (
	input  wire logic                   clk_in,
	input  wire logic                   srst_in,
	input  wire deser_pkg::host_req_t   host_req_in,
	input  wire deser_pkg::remote_req_t remote_req_in,
	input  wire logic                   remote_reject_out,
	input  wire logic                   remote_target_req_in,
	input  wire logic                   remote_target_go_out,
	input  wire logic                   rom_reload_in,
	input  wire logic                   fuse_load_start_out,
	input  wire logic                   txn_start_in,
	input  wire logic                   txn_done_in,
	input  wire logic                   txn_timeout_out,
	input  wire logic [`RX_PORTS-1:0]   parity_flag_clear_in,
	input  wire logic [`RX_PORTS-1:0]   parity_flag_out,
	input  wire logic [2:0]             sda_hold_out,
	input  wire logic [3:0]             glitch_depth_out
);
	import deser_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);

	// ****************
	// sequences
	// ****************
	// host write to the local port config
	sequence cfg_wr_s;
		host_req_in.wr && host_req_in.addr == `OFS_LOCAL_PORT_CFG;
	endsequence
	// remote write racing a host write, host must win
	sequence race_s;
		remote_req_in.wr && host_req_in.wr;
	endsequence

	// ****************
	// assertions
	// ****************
	a_race_rejected: assert property (race_s |=> remote_reject_out)
		else $error("remote write beside host write not refused");
	a_reject_cause: assert property (remote_reject_out |-> $past(remote_req_in.wr))
		else $error("refusal without remote write");
	a_target_passes: assert property (remote_target_go_out == $past(remote_target_req_in))
		else $error("target access not passed on");
	a_reload_starts: assert property (rom_reload_in |=> fuse_load_start_out)
		else $error("reload did not start fuse load");
	a_timeout_pulse: assert property (txn_timeout_out |=> !txn_timeout_out)
		else $error("timeout longer than one cycle");
	a_timeout_early: assert property (txn_start_in |=> !txn_timeout_out [*5])
		else $error("timeout before one unit");
	a_done_stops: assert property (txn_done_in && !txn_start_in |=> !txn_timeout_out [*8])
		else $error("timeout after completion");
	a_cfg_exported: assert property (cfg_wr_s |=> sda_hold_out == $past(host_req_in.wdata[6:4])
		&& glitch_depth_out == $past(host_req_in.wdata[3:0]))
		else $error("hold or filter code not exported");
	a_reset_codes: assert property ($fell(srst_in) |-> sda_hold_out == 3'h1 && glitch_depth_out == 4'hc)
		else $error("hold or filter reset code wrong");
	a_flag_sticky: assert property (!(|($past(parity_flag_out) & ~parity_flag_out
		& ~$past(parity_flag_clear_in))))
		else $error("parity flag dropped without clear");
endmodule

bind deser_status_ctrl_regs deser_status_ctrl_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
	.clk_in, .srst_in, .host_req_in, .remote_req_in, .remote_reject_out, .remote_target_req_in,
	.remote_target_go_out, .rom_reload_in, .fuse_load_start_out, .txn_start_in, .txn_done_in,
	.txn_timeout_out, .parity_flag_clear_in, .parity_flag_out, .sda_hold_out, .glitch_depth_out
);
`default_nettype wire

// ==== tb/fuse_ref_model.sv ====
// fuse loader and divided reference clock source
`timescale 1ns/1ps
`default_nettype none

module fuse_ref_model #(
	parameter int LOAD_CYCLES = 10
) (
	input  wire logic       clk_in,
	input  wire logic       start_in,
	input  wire logic       cksum_in,
	input  wire logic [7:0] ref_half_in,
	output logic            done_out,
	output logic            cksum_out,
	output logic            ref_div_out
);
	int load_cnt = 0;
	int ref_cnt = 0;

	initial begin
		done_out = 1'b0;
		cksum_out = 1'b0;
		ref_div_out = 1'b0;
	end

	// load delay; checksum only meaningful beside done, else it toggles
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		cksum_out <= ~cksum_out;
		if (start_in) begin
			load_cnt <= LOAD_CYCLES;
		end else if (load_cnt == 1) begin
			done_out <= 1'b1;
			cksum_out <= cksum_in;
			load_cnt <= 0;
		end else if (load_cnt != 0) begin
			load_cnt <= load_cnt - 1;
		end
		if (ref_cnt + 1 >= int'(ref_half_in)) begin
			ref_cnt <= 0;
			ref_div_out <= ~ref_div_out;
		end else begin
			ref_cnt <= ref_cnt + 1;
		end
	end
endmodule
`default_nettype wire

// ==== tb/deser_status_ctrl_regs_test.sv ====
// self-checking bench for the status and control register bank
`timescale 1ns/1ps
`default_nettype none
`include "deser_params.svh"

module deser_status_ctrl_regs_test;
	import deser_pkg::*;
	localparam int TICK = 5;
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	host_req_t   hreq = '0;
	remote_req_t rreq = '0;
	logic        treq = 1'b0, reload = 1'b0, en = 1'b1, tst = 1'b0, tdn = 1'b0, cks = 1'b0;
	logic [3:0]  perr = '0, pclr = '0, pflag, depth;
	logic [7:0]  half = 8'h04, rdata;
	logic [2:0]  hold;
	logic        rej, go, fst, fdn, fck, rdiv, tout, irq;
	int          fails = 0, tests_run = 0, cyc = 0;

	always #50 clk_in = ~clk_in;

	deser_status_ctrl_regs #(.TICK_CYCLES(TICK)) dut_u (
		.clk_in(clk_in), .srst_in(srst_in), .host_req_in(hreq), .rdata_out(rdata),
		.remote_req_in(rreq), .remote_reject_out(rej), .remote_target_req_in(treq),
		.remote_target_go_out(go), .rom_reload_in(reload), .fuse_load_start_out(fst),
		.fuse_load_done_in(fdn), .fuse_cksum_valid_in(fck), .ref_clock_div_in(rdiv),
		.parity_check_en_in(en), .parity_error_in(perr), .parity_flag_clear_in(pclr),
		.parity_flag_out(pflag), .txn_start_in(tst), .txn_done_in(tdn), .txn_timeout_out(tout),
		.sda_hold_out(hold), .glitch_depth_out(depth), .irq_out(irq));
	fuse_ref_model #(.LOAD_CYCLES(10)) model_u (
		.clk_in(clk_in), .start_in(fst), .cksum_in(cks), .ref_half_in(half),
		.done_out(fdn), .cksum_out(fck), .ref_div_out(rdiv));

	// ****************
	// shared tasks
	// ****************
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_in) hreq <= '{1'b1, 1'b0, a, d};
		@(posedge clk_in) hreq <= '0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(logic [7:0] a, output logic [7:0] v);
		@(posedge clk_in) hreq <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_in) hreq <= '0;
		#1 v = rdata;
	endtask
	task automatic rw(logic [7:0] a, logic [7:0] d);
		@(posedge clk_in) rreq <= '{1'b1, a, d};
		@(posedge clk_in) rreq <= '0;
		#1;
	endtask
	task automatic cyc_n(int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask
	// pulse a start and count cycles until the watchdog fires
	task automatic span(output int n);
		@(posedge clk_in) tst <= 1'b1;
		@(posedge clk_in) tst <= 1'b0;
		n = 0;
		#1 while (tout !== 1'b1 && n < 60) begin
			@(posedge clk_in);
			#1 n++;
		end
	endtask
	task automatic do_reset();
		@(posedge clk_in) srst_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		srst_in <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic t_reset();
		logic [7:0] a[6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h11, 8'h20};
		logic [7:0] e[6] = '{8'h01, 8'h00, 8'hfe, 8'h1c, 8'h00, 8'h00};
		logic [7:0] v;
		foreach (a[i]) begin
			rd(a[i], v);
			chk("reset", v, e[i]);
		end
		wr(8'h04, 8'h00);
		rd(8'h04, v);
		chk("status", v & 8'hef, 8'hc0);
		chk("hold", hold, 8'h01);
		chk("depth", depth, 8'h0c);
		$display("t_reset finished");
	endtask
	task automatic t_cfg();
		logic [7:0] v;
		wr(8'h08, 8'h7f);
		#1 chk("hold", hold, 8'h07);
		chk("depth", depth, 8'h0f);
		rd(8'h10, v);
		rw(8'h05, 8'h5a);
		chk("rej", rej, 8'h00);
		wr(8'h08, 8'h9c);
		rw(8'h05, 8'h11);
		chk("rej", rej, 8'h01);
		rd(8'h05, v);
		chk("limit", v, 8'h5a);
		// host and remote in one cycle: host wins
		@(posedge clk_in) begin hreq <= '{1'b1, 1'b0, 8'h06, 8'h00}; rreq <= '{1'b1, 8'h06, 8'h33}; end
		@(posedge clk_in) begin hreq <= '0; rreq <= '0; treq <= 1'b1; end
		@(posedge clk_in) treq <= 1'b0;
		#1 chk("go", go, 8'h01);
		rd(8'h10, v);
		chk("sts", v & 8'h02, 8'h02);
		chk("irq", irq, 8'h00);
		$display("t_cfg finished");
	endtask
	task automatic t_parity();
		logic [7:0] v;
		wr(8'h05, 8'h01);
		wr(8'h06, 8'h02);
		wr(8'h11, 8'h04);
		repeat (257) @(posedge clk_in) perr <= 4'h4;
		@(posedge clk_in) perr <= 4'h0;
		#1 chk("flag", pflag, 8'h00);
		@(posedge clk_in) begin en <= 1'b0; perr <= 4'h4; end
		@(posedge clk_in) perr <= 4'h0;
		@(posedge clk_in) en <= 1'b1;
		#1 chk("flag", pflag, 8'h00);
		@(posedge clk_in) perr <= 4'h4;
		@(posedge clk_in) perr <= 4'h0;
		cyc_n(2);
		chk("flag", pflag, 8'h04);
		chk("irq", irq, 8'h01);
		@(posedge clk_in) pclr <= 4'h4;
		@(posedge clk_in) pclr <= 4'h0;
		cyc_n(1);
		chk("clr", pflag, 8'h00);
		rd(8'h10, v);
		chk("sts", v & 8'h04, 8'h04);
		$display("t_parity finished");
	endtask
	task automatic t_wd();
		logic [7:0] v;
		int n;
		wr(8'h11, 8'h01);
		wr(8'h07, 8'h04); // field of two, never zero
		span(n);
		chk("wd", 8'(n), 8'(2 * TICK));
		cyc_n(2);
		chk("irq", irq, 8'h01);
		rd(8'h10, v);
		chk("sts", v & 8'h01, 8'h01);
		chk("irq", irq, 8'h00);
		// restart eight cycles into the ten-cycle run must reload the count
		@(posedge clk_in) tst <= 1'b1;
		@(posedge clk_in) tst <= 1'b0;
		repeat (6) @(posedge clk_in);
		span(n);
		chk("restart", 8'(n), 8'(2 * TICK));
		@(posedge clk_in) tst <= 1'b1;
		@(posedge clk_in) tst <= 1'b0;
		repeat (5) @(posedge clk_in);
		tdn <= 1'b1;
		@(posedge clk_in) tdn <= 1'b0;
		span(n);
		chk("done", 8'(n), 8'(2 * TICK));
		wr(8'h07, 8'h05);
		span(n);
		chk("off", 8'(n), 8'h3c);
		$display("t_wd finished");
	endtask
	task automatic t_reload();
		logic [7:0] v;
		wr(8'h11, 8'h08);
		for (int k = 0; k < 2; k++) begin
			cks <= k[0];
			@(posedge clk_in) reload <= 1'b1;
			@(posedge clk_in) reload <= 1'b0;
			#1 chk("start", fst, 8'h01);
			rd(8'h04, v);
			chk("busy", v & 8'hc0, 8'h00);
			cyc_n(20);
			rd(8'h04, v);
			chk("loaded", v & 8'hc0, {k[0], 7'h40});
			chk("irq", irq, 8'h01);
			rd(8'h10, v);
			chk("sts", v & 8'h08, 8'h08);
		end
		$display("t_reload finished");
	endtask
	// twenty, eighty and ten edges per window
	task automatic t_ref();
		logic [7:0] h[3] = '{8'h04, 8'h01, 8'h08};
		logic [7:0] e[3] = '{8'h10, 8'h00, 8'h00};
		logic [7:0] v;
		foreach (h[i]) begin
			half <= h[i];
			cyc_n(400);
			rd(8'h04, v);
			chk("ref", v & 8'h10, e[i]);
		end
		$display("t_ref finished");
	endtask

	// ****************
	// main sequence and hang guard
	// ****************
	initial begin
		do_reset();
		t_reset();
		t_cfg();
		do_reset();
		t_reset();
		t_parity();
		t_wd();
		t_reload();
		t_ref();
		end_of_test();
	end
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fails++;
			end_of_test();
		end
	end
endmodule
`default_nettype wire
